/* File: logic/hms_defines.svh */
// Purpose: Named encodings and widths for the product/logic/store decoder
// Assumes: 32-bit instruction words, 64-bit general registers
// Notes: Included by the package and every module except hms_mul
`ifndef HMS_DEFINES_SVH
`define HMS_DEFINES_SVH
`define HMS_OP_SPECIAL 6'h00
`define HMS_OP_COP0 6'h10
`define HMS_OP_ORI 6'h0d
`define HMS_OP_SB 6'h28
`define HMS_COP_MT 5'h04
`define HMS_FN_READ_TOP_OP 6'h10
`define HMS_FN_WRITE_TOP_OP 6'h11
`define HMS_FN_READ_BOTTOM_OP 6'h12
`define HMS_FN_WRITE_BOTTOM_OP 6'h13
`define HMS_FN_SIGNED_PRODUCT_OP 6'h18
`define HMS_FN_UNSIGNED_PRODUCT_OP 6'h19
`define HMS_FN_DIV 6'h1a
`define HMS_FN_UNSIGNED_QUOTIENT_OP 6'h1b
`define HMS_FN_OR 6'h25
`define HMS_FN_NOR 6'h27
`define HMS_OP_MSB 31
`define HMS_OP_LSB 26
`define HMS_RS_MSB 25
`define HMS_RS_LSB 21
`define HMS_RT_MSB 20
`define HMS_RT_LSB 16
`define HMS_RD_MSB 15
`define HMS_RD_LSB 11
`define HMS_FN_MSB 5
`define HMS_FN_LSB 0
`define HMS_IMM_MSB 15
`define HMS_WORD_MSB 31
`define HMS_MODE_USER 2'h2
`define HMS_MODE_SUPER 2'h1
`endif

/* File: logic/hms_pkg.sv */
// Purpose: Types shared by the decoder and its multiplier
// Assumes: hms_defines.svh present
// Notes: Carriers for write-back and store requests
`include "hms_defines.svh"
package hms_pkg;
  typedef logic [63:0] hms_word_t;
  typedef logic [4:0] hms_reg_t;

  typedef struct packed {
    logic en;
    hms_reg_t idx;
    hms_word_t data;
  } hms_wb_s;

  typedef struct packed {
    logic en;
    hms_word_t vaddr;
    logic [7:0] data;
  } hms_store_s;

  typedef enum logic [2:0] {
    HMS_IDLE = 3'b001,
    HMS_CP0_WAIT = 3'b010,
    HMS_CP0_WRITE = 3'b100
  } hms_cp0_state_e;
endpackage : hms_pkg

/* File: logic/hms_mul.sv */
// Purpose: 32x32 multiplier giving a 64-bit product, signed or unsigned
// Assumes: Operands are low 32 bits of the sources
// Notes: Combinational; the caller registers the result
`timescale 1ns/1ps
module hms_mul
  import hms_pkg::*;
(
  input wire logic is_signed,
  input wire logic [31:0] opa,
  input wire logic [31:0] opb,
  output logic [63:0] prod
);
  logic [65:0] full;

  always_comb begin
    full = $signed({is_signed & opa[31], is_signed & opa[31], opa}) *
           $signed({is_signed & opb[31], is_signed & opb[31], opb});
    prod = full[63:0];
  end
endmodule : hms_mul

/* File: logic/hms_decoder.sv */
// Purpose: Decode and execute product-register moves, cop0 write,
//          32-bit multiply, NOR/OR/OR_IMMEDIATE and store byte
// Assumes: Register file read data arrives in the issue cycle
// Notes: One instruction per valid cycle; results registered
`timescale 1ns/1ps
`include "hms_defines.svh"

// Functional notes
// - read_bottom_op copies product_bottom_reg into destination register.
// - write_system_coprocessor writes cop0 register two cycles after read.
// - Cop0 write in user or supervisor mode, cop0 disabled, faults.
// - write_top_op loads source_a register into product_top_reg.
// - write_top_op right after product/quotient may spoil bottom register.
// - write_bottom_op loads source_a register into product_bottom_reg.
// - write_bottom_op right after product/quotient may spoil top register.
// - signed_product_op multiplies signed 32-bit, no overflow exception.
// - Product low word to bottom, high to top, sign-extended from 31 if MODE_64, else upper half zero.
// - unsigned_product_op multiplies unsigned 32-bit, no overflow.
// - NOR writes bitwise NOR of both sources to destination.
// - OR writes bitwise OR of both sources to destination.
// - or_immediate zero-extends immediate, ORs source_a, writes source_b.
// - store_byte address is sign-extended offset plus base; low byte.
module hms_decoder
  import hms_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR,
  input wire logic [63:0] SRC_A_DATA,
  input wire logic [63:0] SRC_B_DATA,
  input wire logic MODE_64,
  input wire logic [1:0] PRIV_MODE,
  input wire logic COP0_ENABLE,
  input wire logic QUOT_DONE,
  input wire logic [63:0] QUOT_BOTTOM,
  input wire logic [63:0] QUOT_TOP,
  output logic GPR_WE,
  output logic [4:0] GPR_WADDR,
  output logic [63:0] GPR_WDATA,
  output logic COP0_WE,
  output logic [4:0] COP0_WADDR,
  output logic [63:0] COP0_WDATA,
  output logic STORE_EN,
  output logic [63:0] STORE_VADDR,
  output logic [7:0] STORE_DATA,
  output logic COP_UNUSABLE,
  output logic [63:0] PRODUCT_TOP,
  output logic [63:0] PRODUCT_BOTTOM
);
  logic [5:0] opcode;
  logic [5:0] funct;
  logic [4:0] fld_a;
  logic [4:0] fld_b;
  logic [4:0] fld_d;
  logic is_special;
  logic dec_read_top;
  logic dec_read_bottom;
  logic dec_write_top;
  logic dec_write_bottom;
  logic dec_signed_product_op;
  logic dec_unsigned_product_op;
  logic dec_quot;
  logic dec_nor;
  logic dec_or;
  logic dec_ori;
  logic dec_sb;
  logic dec_write_system_coprocessor;
  logic cop0_fault;
  logic [63:0] prod;
  logic [63:0] nxt_top;
  logic [63:0] nxt_bottom;
  hms_wb_s nxt_wb;
  hms_wb_s wb_ff;
  hms_store_s nxt_st;
  hms_store_s st_ff;
  hms_cp0_state_e cp0_state_ff;
  logic [4:0] cp0_idx_ff;
  logic [63:0] cp0_data_ff;
  logic [63:0] top_ff;
  logic [63:0] bottom_ff;
  logic fault_ff;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  always_comb begin
    opcode = INSTR[`HMS_OP_MSB:`HMS_OP_LSB];
    funct = INSTR[`HMS_FN_MSB:`HMS_FN_LSB];
    fld_a = INSTR[`HMS_RS_MSB:`HMS_RS_LSB];
    fld_b = INSTR[`HMS_RT_MSB:`HMS_RT_LSB];
    fld_d = INSTR[`HMS_RD_MSB:`HMS_RD_LSB];
    is_special = INSTR_VALID && (opcode == `HMS_OP_SPECIAL);
    dec_read_top = is_special && (funct == `HMS_FN_READ_TOP_OP);
    dec_read_bottom = is_special && (funct == `HMS_FN_READ_BOTTOM_OP);
    dec_write_top = is_special && (funct == `HMS_FN_WRITE_TOP_OP);
    dec_write_bottom = is_special && (funct == `HMS_FN_WRITE_BOTTOM_OP);
    dec_signed_product_op = is_special && (funct == `HMS_FN_SIGNED_PRODUCT_OP);
    dec_unsigned_product_op = is_special && (funct == `HMS_FN_UNSIGNED_PRODUCT_OP);
    dec_quot = is_special &&
      ((funct == `HMS_FN_DIV) || (funct == `HMS_FN_UNSIGNED_QUOTIENT_OP));
    dec_nor = is_special && (funct == `HMS_FN_NOR);
    dec_or = is_special && (funct == `HMS_FN_OR);
    dec_ori = INSTR_VALID && (opcode == `HMS_OP_ORI);
    dec_sb = INSTR_VALID && (opcode == `HMS_OP_SB);
    dec_write_system_coprocessor = INSTR_VALID && (opcode == `HMS_OP_COP0) &&
      (fld_a == `HMS_COP_MT);
  end

  // ------------------------------------------------------------
  // Multiplier
  // ------------------------------------------------------------
  // signed multiply select
  hms_mul u_mul (
    .is_signed(dec_signed_product_op),
    .opa(SRC_A_DATA[`HMS_WORD_MSB:0]),
    .opb(SRC_B_DATA[`HMS_WORD_MSB:0]),
    .prod(prod)
  );

  // ------------------------------------------------------------
  // Product registers
  // ------------------------------------------------------------
  always_comb begin
    nxt_top = top_ff;
    nxt_bottom = bottom_ff;
    if (dec_signed_product_op || dec_unsigned_product_op) begin
      nxt_bottom = {{32{prod[31]}}, prod[31:0]};
      nxt_top = {{32{prod[63]}}, prod[63:32]};
      if (!MODE_64) begin
        nxt_bottom[63:32] = '0;
        nxt_top[63:32] = '0;
      end
    end else if (QUOT_DONE) begin
      nxt_bottom = QUOT_BOTTOM;
      nxt_top = QUOT_TOP;
    end
    // load top; bottom kept as is
    if (dec_write_top)
      nxt_top = SRC_A_DATA;
    // load bottom; top kept as is
    if (dec_write_bottom)
      nxt_bottom = SRC_A_DATA;
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      top_ff <= '0;
      bottom_ff <= '0;
    end else begin
      top_ff <= nxt_top;
      bottom_ff <= nxt_bottom;
    end
  end

  // ------------------------------------------------------------
  // General register write-back
  // ------------------------------------------------------------
  always_comb begin
    nxt_wb = '0;
    if (dec_read_bottom) begin
      nxt_wb = '{en: 1'b1, idx: fld_d, data: bottom_ff};
    end else if (dec_read_top) begin
      nxt_wb = '{en: 1'b1, idx: fld_d, data: top_ff};
    end else if (dec_nor) begin
      nxt_wb = '{en: 1'b1, idx: fld_d, data: ~(SRC_A_DATA | SRC_B_DATA)};
    end else if (dec_or) begin
      nxt_wb = '{en: 1'b1, idx: fld_d, data: SRC_A_DATA | SRC_B_DATA};
    end else if (dec_ori) begin
      nxt_wb = '{en: 1'b1, idx: fld_b,
        data: SRC_A_DATA | {48'h0, INSTR[`HMS_IMM_MSB:0]}};
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N)
      wb_ff <= '0;
    else
      wb_ff <= nxt_wb;
  end

  // ------------------------------------------------------------
  // Store byte
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = '0;
    if (dec_sb) begin
      nxt_st.en = 1'b1;
      nxt_st.vaddr = SRC_A_DATA +
        {{48{INSTR[`HMS_IMM_MSB]}}, INSTR[`HMS_IMM_MSB:0]};
      if (!MODE_64)
        nxt_st.vaddr[63:32] = '0;
      nxt_st.data = SRC_B_DATA[7:0];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // ------------------------------------------------------------
  // Coprocessor 0 write
  // ------------------------------------------------------------
  // privilege check
  assign cop0_fault = dec_write_system_coprocessor && !COP0_ENABLE &&
    ((PRIV_MODE == `HMS_MODE_USER) || (PRIV_MODE == `HMS_MODE_SUPER));

  // read at T, write at T+2
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      cp0_state_ff <= HMS_IDLE;
      cp0_idx_ff <= '0;
      cp0_data_ff <= '0;
    end else begin
      case (cp0_state_ff)
        HMS_IDLE, HMS_CP0_WRITE: begin
          if (dec_write_system_coprocessor && !cop0_fault) begin
            cp0_state_ff <= HMS_CP0_WAIT;
            cp0_idx_ff <= fld_d;
            cp0_data_ff <= SRC_B_DATA;
          end else begin
            cp0_state_ff <= HMS_IDLE;
          end
        end
        HMS_CP0_WAIT: begin
          cp0_state_ff <= HMS_CP0_WRITE;
        end
        default: cp0_state_ff <= HMS_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N)
      fault_ff <= 1'b0;
    else
      fault_ff <= cop0_fault;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign GPR_WE = wb_ff.en;
  assign GPR_WADDR = wb_ff.idx;
  assign GPR_WDATA = wb_ff.data;
  assign COP0_WE = (cp0_state_ff == HMS_CP0_WRITE);
  assign COP0_WADDR = cp0_idx_ff;
  assign COP0_WDATA = cp0_data_ff;
  assign STORE_EN = st_ff.en;
  assign STORE_VADDR = st_ff.vaddr;
  assign STORE_DATA = st_ff.data;
  assign COP_UNUSABLE = fault_ff;
  assign PRODUCT_TOP = top_ff;
  assign PRODUCT_BOTTOM = bottom_ff;
endmodule : hms_decoder

/* File: sim/hms_decoder_checker.sv */
// Purpose: Port assertions for hms_decoder
// Assumes: Results one cycle after issue, cop0 write two
// Notes: Bound into every hms_decoder
`timescale 1ns/1ps
`include "hms_defines.svh"
module hms_decoder_checker
  import hms_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR,
  input wire logic [63:0] SRC_A_DATA,
  input wire logic [63:0] SRC_B_DATA,
  input wire logic MODE_64,
  input wire logic [1:0] PRIV_MODE,
  input wire logic COP0_ENABLE,
  input wire logic QUOT_DONE,
  input wire logic GPR_WE,
  input wire logic [63:0] GPR_WDATA,
  input wire logic COP0_WE,
  input wire logic [63:0] COP0_WDATA,
  input wire logic STORE_EN,
  input wire logic [63:0] STORE_VADDR,
  input wire logic COP_UNUSABLE,
  input wire logic [63:0] PRODUCT_TOP,
  input wire logic [63:0] PRODUCT_BOTTOM
);
  // ---
  // Decode
  // ---
  logic sp, mc, bad;
  logic [31:0] a32, oim;
  hms_word_t ab, lg, sum, va;
  assign sp = INSTR_VALID && INSTR[31:26] == `HMS_OP_SPECIAL;
  assign mc = INSTR_VALID && INSTR[31:21] == {`HMS_OP_COP0, `HMS_COP_MT};
  assign bad = PRIV_MODE != 2'h0 && !COP0_ENABLE;
  assign a32 = SRC_A_DATA[31:0];
  assign ab = SRC_A_DATA | SRC_B_DATA;
  assign lg = INSTR[1] ? ~ab : ab;
  assign oim = a32 | {16'h0, INSTR[15:0]};
  assign sum = SRC_A_DATA + {{48{INSTR[15]}}, INSTR[15:0]};
  assign va = {MODE_64 ? sum[63:32] : 32'h0, sum[31:0]};
  // ---
  // Assertions
  // ---
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);
  sequence s_cop_ok;
    mc && !bad && !$past(mc);
  endsequence
  sequence s_cop_bad;
    mc && bad;
  endsequence
  chk_logic_write: assert property (
    sp && INSTR[5:0] inside {`HMS_FN_OR, `HMS_FN_NOR} |=> GPR_WE &&
    GPR_WDATA == $past(lg)) else $error("logic result wrong");
  chk_imm_or: assert property (
    INSTR_VALID && INSTR[31:26] == `HMS_OP_ORI |=> GPR_WE &&
    GPR_WDATA[31:0] == $past(oim)) else $error("immediate or wrong");
  chk_bottom_read: assert property (
    sp && INSTR[5:0] == `HMS_FN_READ_BOTTOM_OP |=> GPR_WE &&
    GPR_WDATA == $past(PRODUCT_BOTTOM)) else $error("bottom read wrong");
  chk_bottom_load: assert property (
    sp && INSTR[5:0] == `HMS_FN_WRITE_BOTTOM_OP |=>
    PRODUCT_BOTTOM[31:0] == $past(a32)) else $error("bottom load wrong");
  chk_cop_write: assert property (
    s_cop_ok |=> !COP_UNUSABLE ##1 COP0_WE &&
    COP0_WDATA == $past(SRC_B_DATA, 2)) else $error("cop0 write wrong");
  chk_cop_refuse: assert property (
    s_cop_bad |=> COP_UNUSABLE ##1 !COP0_WE) else $error("no refusal");
  chk_store_addr: assert property (
    INSTR_VALID && INSTR[31:26] == `HMS_OP_SB |=> STORE_EN &&
    STORE_VADDR == $past(va)) else $error("store address wrong");
  chk_product_hold: assert property (
    !INSTR_VALID && !QUOT_DONE |=> $stable(PRODUCT_TOP) &&
    $stable(PRODUCT_BOTTOM)) else $error("product register moved");
endmodule : hms_decoder_checker

bind hms_decoder hms_decoder_checker u_chk (.CLK_SYS, .RESET_N,
  .INSTR_VALID, .INSTR, .SRC_A_DATA, .SRC_B_DATA, .MODE_64, .PRIV_MODE,
  .COP0_ENABLE, .QUOT_DONE, .GPR_WE, .GPR_WDATA, .COP0_WE, .COP0_WDATA,
  .STORE_EN, .STORE_VADDR, .COP_UNUSABLE, .PRODUCT_TOP, .PRODUCT_BOTTOM);

/* File: sim/test_hilo_move_signed_product_op_logic_store_byte.sv */
// Purpose: Random and corner bench for hms_decoder
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Idle slots keep the software hazard spacing
`timescale 1ns/1ps
`include "hms_defines.svh"
module test_hilo_move_signed_product_op_logic_store_byte
  import hms_pkg::*;
;
  logic CLK_SYS, RESET_N, INSTR_VALID, MODE_64, COP0_ENABLE, QUOT_DONE;
  logic GPR_WE, COP0_WE, STORE_EN, COP_UNUSABLE, c0_p;
  logic [31:0] INSTR, x;
  logic [1:0] PRIV_MODE;
  logic [7:0] STORE_DATA;
  hms_reg_t GPR_WADDR, COP0_WADDR, c0_a;
  hms_word_t SRC_A_DATA, SRC_B_DATA, QUOT_BOTTOM, QUOT_TOP, GPR_WDATA;
  hms_word_t COP0_WDATA, STORE_VADDR, PRODUCT_TOP, PRODUCT_BOTTOM;
  hms_word_t e_top, e_bot, c0_d;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] tm [11] = '{{26'h0, `HMS_FN_OR}, {26'h0, `HMS_FN_NOR},
    {26'h0, `HMS_FN_READ_BOTTOM_OP}, {26'h0, `HMS_FN_READ_TOP_OP}, {26'h0, `HMS_FN_WRITE_BOTTOM_OP},
    {26'h0, `HMS_FN_WRITE_TOP_OP}, {26'h0, `HMS_FN_SIGNED_PRODUCT_OP}, {26'h0, `HMS_FN_UNSIGNED_PRODUCT_OP},
    {`HMS_OP_ORI, 26'h0}, {`HMS_OP_SB, 26'h0},
    {`HMS_OP_COP0, `HMS_COP_MT, 21'h0}};

  hms_decoder uut (.CLK_SYS, .RESET_N, .INSTR_VALID, .INSTR, .SRC_A_DATA,
    .SRC_B_DATA, .MODE_64, .PRIV_MODE, .COP0_ENABLE, .QUOT_DONE,
    .QUOT_BOTTOM, .QUOT_TOP, .GPR_WE, .GPR_WADDR, .GPR_WDATA, .COP0_WE,
    .COP0_WADDR, .COP0_WDATA, .STORE_EN, .STORE_VADDR, .STORE_DATA,
    .COP_UNUSABLE, .PRODUCT_TOP, .PRODUCT_BOTTOM);

  // ---
  // Helpers
  // ---
  function automatic hms_word_t wx(input logic [31:0] w, input logic s);
    return {s ? {32{w[31]}} : 32'h0, w};
  endfunction : wx

  function automatic logic [31:0] pick(input int k);
    return tm[k] | ($urandom & (k < 8 ? 32'h03ff_f800 :
      k < 10 ? 32'h03ff_ffff : 32'h001f_f800));
  endfunction : pick

  task automatic chk(input string nm, input hms_word_t e, input hms_word_t s);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  task automatic step(input logic v, input logic [31:0] ins,
    input hms_word_t a, input hms_word_t b);
    logic sp, mc, we, st, cu;
    hms_reg_t wa;
    hms_word_t p, wd, va;
    sp = v && ins[31:26] == `HMS_OP_SPECIAL;
    mc = v && ins[31:21] == {`HMS_OP_COP0, `HMS_COP_MT};
    a = wx(a[31:0], MODE_64);
    b = wx(b[31:0], MODE_64);
    p = wx(a[31:0], !ins[0]) * wx(b[31:0], !ins[0]);
    {we, wd, wa} = {65'h0, ins[15:11]};
    cu = mc && PRIV_MODE != 2'h0 && !COP0_ENABLE;
    QUOT_DONE = !v && $urandom_range(3) == 0;
    QUOT_TOP = {$urandom, $urandom};
    QUOT_BOTTOM = {$urandom, $urandom};
    if (QUOT_DONE) {e_top, e_bot} = {QUOT_TOP, QUOT_BOTTOM};
    va = a + {{48{ins[15]}}, ins[15:0]};
    if (!MODE_64) va[63:32] = 32'h0;
    st = v && ins[31:26] == `HMS_OP_SB;
    if (v && ins[31:26] == `HMS_OP_ORI)
      {we, wd, wa} = {1'b1, a | ins[15:0], ins[20:16]};
    if (sp)
      case (ins[5:0])
        `HMS_FN_OR: {we, wd} = {1'b1, a | b};
        `HMS_FN_NOR: {we, wd} = {1'b1, ~(a | b)};
        `HMS_FN_READ_BOTTOM_OP: {we, wd} = {1'b1, e_bot};
        `HMS_FN_READ_TOP_OP: {we, wd} = {1'b1, e_top};
        `HMS_FN_WRITE_BOTTOM_OP: e_bot = a;
        `HMS_FN_WRITE_TOP_OP: e_top = a;
        `HMS_FN_SIGNED_PRODUCT_OP, `HMS_FN_UNSIGNED_PRODUCT_OP:
          {e_top, e_bot} = {wx(p[63:32], MODE_64), wx(p[31:0], MODE_64)};
        default: ;
      endcase
    {INSTR_VALID, INSTR, SRC_A_DATA, SRC_B_DATA} = {v, ins, a, b};
    @(posedge CLK_SYS);
    #1;
    chk("gpr_we", we, GPR_WE);
    if (we) chk("gpr_addr", wa, GPR_WADDR);
    if (we) chk("gpr_data", wd, GPR_WDATA);
    chk("store_en", st, STORE_EN);
    if (st) chk("store_addr", va, STORE_VADDR);
    if (st) chk("store_data", b[7:0], STORE_DATA);
    chk("top", e_top, PRODUCT_TOP);
    chk("bottom", e_bot, PRODUCT_BOTTOM);
    chk("unusable", cu, COP_UNUSABLE);
    chk("cop_we", c0_p, COP0_WE);
    if (c0_p) chk("cop_addr", c0_a, COP0_WADDR);
    if (c0_p) chk("cop_data", c0_d, COP0_WDATA);
    {c0_p, c0_a, c0_d} = {mc && !cu, ins[15:11], b};
  endtask : step

  task automatic run(input logic [31:0] ins, input hms_word_t a, b);
    logic g;
    g = ins[31:26] == `HMS_OP_COP0 || ins[31:26] == 6'h0 && ins[5:2] == 4'h4;
    if (g) step(0, ins, a, b);
    step(1, ins, a, b);
    if (g) repeat (2) step(0, ins, a, b);
  endtask : run

  task automatic tally_and_finish();
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // ---
  // Sequence
  // ---
  initial begin
    CLK_SYS = 0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end

  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    {RESET_N, INSTR_VALID, MODE_64, COP0_ENABLE, QUOT_DONE, c0_p} = 6'h0;
    {INSTR, PRIV_MODE, SRC_A_DATA, SRC_B_DATA, QUOT_TOP, QUOT_BOTTOM} = 0;
    {e_top, e_bot} = 0;
    void'($urandom(32'h4e5ed793));
    repeat (2) @(posedge CLK_SYS);
    #1;
    RESET_N = 1;
    for (int i = 0; i < 8; i++) begin
      MODE_64 = i[2];
      x = i[1] ? 32'hffff_ffff : 32'h8000_0000;
      run(tm[6 + i[0]], x, x);
      run({`HMS_OP_SB, 10'h3ff, 16'h8000}, 0, 64'h1a5);
      run({`HMS_OP_ORI, 10'h0a5, 16'hffff}, 64'h8000_1234, 0);
      PRIV_MODE = 2'(i % 3);
      COP0_ENABLE = i[2];
      run(pick(10), $urandom, $urandom);
    end
    for (int r = 0; r < 2; r++) begin
      repeat (200) begin
        {MODE_64, COP0_ENABLE} = 2'($urandom);
        PRIV_MODE = 2'($urandom_range(2));
        run(pick($urandom_range(10)), {$urandom, $urandom}, {$urandom, 32'h0});
      end
      RESET_N = 0;
      @(posedge CLK_SYS);
      #1;
      chk("reset_top", 0, PRODUCT_TOP);
      RESET_N = 1;
      {e_top, e_bot} = 0;
    end
    tally_and_finish();
  end
endmodule : test_hilo_move_signed_product_op_logic_store_byte
